/* src/exec_unit.v */
// Execution datapath for power-down, increment, jump, move, OR, return and rotate
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "exec_unit_defs.vh"

module exec_unit (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Core status
   output reg halted,
   output reg global_irq_enable
);

   localparam ST_IDLE = 2'b00;
   localparam ST_EXEC = 2'b01;
   localparam ST_RET2 = 2'b10;
   localparam ST_HALT = 2'b11;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [31:0] instr_reg;
   reg [7:0] acc_reg;
   reg [7:0] acc_next;
   reg [11:0] pc_reg;
   reg [11:0] pc_next;
   reg carry_reg;
   reg carry_next;
   reg zero_reg;
   reg zero_next;
   reg powerdown_flag;
   reg watchdog_expired_flag;
   reg badop_reg;
   reg badop_next;
   reg gie_next;
   reg [7:0] watchdog_counter;
   reg [7:0] prescaler_reg;
   reg [7:0] mem_addr_reg;
   reg [11:0] stack_mem [0:`STACK_DEPTH-1];
   reg [2:0] sp_reg;
   reg pop_en;
   reg mem_we_exec;
   reg [7:0] mem_wdata_exec;
   reg halt_go;

   wire [4:0] opc;
   wire [7:0] imm;
   wire [11:0] jaddr;
   wire [7:0] mbyte;
   wire [7:0] mem_addr;
   wire mem_we;
   wire [7:0] mem_wdata;
   wire [7:0] inc_val;
   wire [11:0] stack_top;
   wire acc_phase;
   wire wr_fire;
   wire engine_free;
   wire wr_instr;
   wire wr_mem;
   wire wr_push;
   wire wr_refused;

   // Zero flag source: set exactly when the result byte is all zeros
   function zflag;
      input [7:0] v;
      begin
         zflag = (v == 8'h00);
      end
   endfunction

   // Register selection helper
   function sel;
      input [7:0] a;
      input [7:0] ofs;
      begin
         sel = (a == ofs);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Instruction fields and shared datapath terms

   assign opc = instr_reg[`INSTR_OPC_HI:`INSTR_OPC_LO];
   assign imm = instr_reg[`INSTR_IMM_HI:`INSTR_IMM_LO];
   assign jaddr = instr_reg[`INSTR_ADR_HI:`INSTR_ADR_LO];
   assign inc_val = mbyte + 8'h01;
   assign stack_top = (sp_reg == 3'd0) ? 12'h000 : stack_mem[sp_reg - 3'd1];
   assign engine_free = (state_reg == ST_IDLE);

   // APB phases: answer one cycle into the access phase
   assign acc_phase = psel && penable;
   assign wr_fire = acc_phase && pready && pwrite;
   assign wr_refused = (sel(paddr, `OFS_INSTR) || sel(paddr, `OFS_MEM_DATA) ||
                        sel(paddr, `OFS_STACK)) && !engine_free;
   assign wr_instr = wr_fire && sel(paddr, `OFS_INSTR) && engine_free;
   assign wr_mem = wr_fire && sel(paddr, `OFS_MEM_DATA) && engine_free;
   assign wr_push = wr_fire && sel(paddr, `OFS_STACK) && engine_free &&
                    (sp_reg != `STACK_DEPTH);

   // Memory port shared between the engine and software
   assign mem_addr = (state_reg == ST_EXEC) ? jaddr[7:0] : mem_addr_reg;
   assign mem_we = mem_we_exec || wr_mem;
   assign mem_wdata = mem_we_exec ? mem_wdata_exec : pwdata[7:0];

   data_mem u_dmem (
      .clk(pclk),
      .addr(mem_addr),
      .wr_en(mem_we),
      .wr_data(mem_wdata),
      .rd_data(mbyte)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Instruction execution

   always @* begin
      state_next = state_reg;
      acc_next = acc_reg;
      pc_next = pc_reg;
      carry_next = carry_reg;
      zero_next = zero_reg;
      gie_next = global_irq_enable;
      badop_next = badop_reg;
      pop_en = 1'b0;
      mem_we_exec = 1'b0;
      mem_wdata_exec = 8'h00;
      halt_go = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (wr_instr) begin
               state_next = ST_EXEC;
            end
         end
         ST_EXEC: begin
            state_next = ST_IDLE;
            pc_next = pc_reg + 12'h001;
            case (opc)
               `OP_HALT: begin
                  halt_go = 1'b1;
                  state_next = ST_HALT;
               end
               `OP_INC: begin
                  mem_we_exec = 1'b1;
                  mem_wdata_exec = inc_val;
                  zero_next = zflag(inc_val);
               end
               `OP_INCREMENT_TO_ACC_OP: begin
                  acc_next = inc_val;
                  zero_next = zflag(inc_val);
               end
               `OP_JUMP: begin
                  pc_next = jaddr;
               end
               `OP_MOV_A_M: begin
                  acc_next = mbyte;
               end
               `OP_MOV_A_X: begin
                  acc_next = imm;
               end
               `OP_MOV_M_A: begin
                  mem_we_exec = 1'b1;
                  mem_wdata_exec = acc_reg;
               end
               `OP_NOP: begin
                  pc_next = pc_reg + 12'h001;
               end
               `OP_OR_A_M: begin
                  acc_next = acc_reg | mbyte;
                  zero_next = zflag(acc_reg | mbyte);
               end
               `OP_OR_A_X: begin
                  acc_next = acc_reg | imm;
                  zero_next = zflag(acc_reg | imm);
               end
               `OP_OR_M: begin
                  mem_we_exec = 1'b1;
                  mem_wdata_exec = acc_reg | mbyte;
                  zero_next = zflag(acc_reg | mbyte);
               end
               `OP_RET: begin
                  pc_next = pc_reg;
                  state_next = ST_RET2;
               end
               `OP_RET_A_X: begin
                  pc_next = pc_reg;
                  acc_next = imm;
                  state_next = ST_RET2;
               end
               `OP_IRQ_RET: begin
                  pc_next = pc_reg;
                  gie_next = 1'b1;
                  state_next = ST_RET2;
               end
               `OP_ROT_L: begin
                  mem_we_exec = 1'b1;
                  mem_wdata_exec = {mbyte[6:0], mbyte[7]};
               end
               `OP_ROT_L_ACC: begin
                  acc_next = {mbyte[6:0], mbyte[7]};
               end
               `OP_ROT_LC: begin
                  mem_we_exec = 1'b1;
                  mem_wdata_exec = {mbyte[6:0], carry_reg};
                  carry_next = mbyte[7];
               end
               `OP_ROT_LC_ACC: begin
                  acc_next = {mbyte[6:0], carry_reg};
                  carry_next = mbyte[7];
               end
               `OP_ROT_R: begin
                  mem_we_exec = 1'b1;
                  mem_wdata_exec = {mbyte[0], mbyte[7:1]};
               end
               `OP_ROT_R_ACC: begin
                  acc_next = {mbyte[0], mbyte[7:1]};
               end
               `OP_ROT_RC: begin
                  mem_we_exec = 1'b1;
                  mem_wdata_exec = {carry_reg, mbyte[7:1]};
                  carry_next = mbyte[0];
               end
               `OP_ROT_RC_ACC: begin
                  acc_next = {carry_reg, mbyte[7:1]};
                  carry_next = mbyte[0];
               end
               default: begin
                  badop_next = 1'b1; // Unknown code acts as no-operation
               end
            endcase
         end
         ST_RET2: begin
            pop_en = 1'b1;
            pc_next = stack_top;
            state_next = ST_IDLE;
         end
         ST_HALT: begin
            // Nothing executes until software wakes the core
            if (wr_fire && sel(paddr, `OFS_WAKE)) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      // Software writes to core registers when the engine is idle
      if (engine_free && wr_fire) begin
         if (sel(paddr, `OFS_ACC)) begin
            acc_next = pwdata[7:0];
         end
         if (sel(paddr, `OFS_PC)) begin
            pc_next = pwdata[11:0];
         end
         if (sel(paddr, `OFS_STATUS)) begin
            carry_next = pwdata[`ST_CARRY];
            zero_next = pwdata[`ST_ZERO];
            badop_next = 1'b0;
         end
         if (sel(paddr, `OFS_IRQ_CTRL)) begin
            gie_next = pwdata[`IRQ_GIE_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Core state registers

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         instr_reg <= 32'h00000000;
         acc_reg <= `RST_ACC;
         pc_reg <= `RST_PC;
         carry_reg <= 1'b0;
         zero_reg <= 1'b0;
         badop_reg <= 1'b0;
         global_irq_enable <= 1'b0;
         halted <= 1'b0;
      end else begin
         state_reg <= state_next;
         acc_reg <= acc_next;
         pc_reg <= pc_next;
         carry_reg <= carry_next;
         zero_reg <= zero_next;
         badop_reg <= badop_next;
         global_irq_enable <= gie_next;
         halted <= (state_next == ST_HALT);
         if (wr_instr) begin
            instr_reg <= pwdata;
         end
      end
   end

   // Power-down and time-out flags, watchdog counter and its prescaler
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         powerdown_flag <= 1'b0;
         watchdog_expired_flag <= 1'b0;
         watchdog_counter <= `RST_WDT;
         prescaler_reg <= `RST_WDT;
      end else if (halt_go) begin
         powerdown_flag <= 1'b1;
         watchdog_expired_flag <= 1'b0;
         watchdog_counter <= `RST_WDT;
         prescaler_reg <= `RST_WDT;
      end else if (state_reg != ST_HALT) begin
         // Counting stops with the clock in power-down
         prescaler_reg <= prescaler_reg + 8'h01;
         if (prescaler_reg == 8'hFF) begin
            watchdog_counter <= watchdog_counter + 8'h01;
         end
      end
   end

   // Return stack: software pushes, returns pop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_reg <= 3'd0;
      end else if (pop_en && (sp_reg != 3'd0)) begin
         sp_reg <= sp_reg - 3'd1;
      end else if (wr_push) begin
         sp_reg <= sp_reg + 3'd1;
      end
   end

   // Stack storage, no reset needed
   always @(posedge pclk) begin
      if (wr_push) begin
         stack_mem[sp_reg] <= pwdata[11:0];
      end
   end

   // Software memory pointer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_addr_reg <= 8'h00;
      end else if (wr_fire && sel(paddr, `OFS_MEM_ADDR)) begin
         mem_addr_reg <= pwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, read data captured at first access edge

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= acc_phase && !pready;
         pslverr <= 1'b0;
         if (acc_phase && !pready) begin
            prdata <= 32'h00000000;
            if (pwrite) begin
               pslverr <= wr_refused;
            end else begin
               case (paddr)
                  `OFS_INSTR: prdata <= instr_reg;
                  `OFS_STATUS: prdata <= {25'h0000000, badop_reg, halted,
                                          !engine_free, watchdog_expired_flag,
                                          powerdown_flag, zero_reg, carry_reg};
                  `OFS_ACC: prdata <= {24'h000000, acc_reg};
                  `OFS_PC: prdata <= {20'h00000, pc_reg};
                  `OFS_IRQ_CTRL: prdata <= {31'h00000000, global_irq_enable};
                  `OFS_MEM_ADDR: prdata <= {24'h000000, mem_addr_reg};
                  `OFS_MEM_DATA: prdata <= {24'h000000, mbyte};
                  `OFS_STACK: prdata <= {29'h00000000, sp_reg};
                  `OFS_WAKE: prdata <= 32'h00000000;
                  `OFS_WDT: prdata <= {16'h0000, prescaler_reg, watchdog_counter};
                  default: pslverr <= 1'b1;
               endcase
            end
         end
      end
   end

endmodule // exec_unit

/* src/exec_unit_defs.vh */
// Register map, instruction fields, opcodes and reset values of the execution unit
`ifndef EXEC_UNIT_DEFS_VH
`define EXEC_UNIT_DEFS_VH

// Register byte offsets
`define OFS_INSTR      8'h00
`define OFS_STATUS     8'h04
`define OFS_ACC        8'h08
`define OFS_PC         8'h0C
`define OFS_IRQ_CTRL   8'h10
`define OFS_MEM_ADDR   8'h14
`define OFS_MEM_DATA   8'h18
`define OFS_STACK      8'h1C
`define OFS_WAKE       8'h20
`define OFS_WDT        8'h24

// Instruction word fields
`define INSTR_OPC_HI   28
`define INSTR_OPC_LO   24
`define INSTR_ADR_HI   19
`define INSTR_ADR_LO   8
`define INSTR_IMM_HI   7
`define INSTR_IMM_LO   0

// Status register bit positions
`define ST_CARRY       0
`define ST_ZERO        1
`define ST_PDOWN       2
`define ST_WDTO        3
`define ST_BUSY        4
`define ST_HALTED      5
`define ST_BADOP       6

// Interrupt control bit position
`define IRQ_GIE_BIT    0

// Opcodes
`define OP_HALT        5'h00
`define OP_INC         5'h01
`define OP_INCREMENT_TO_ACC_OP        5'h02
`define OP_JUMP        5'h03
`define OP_MOV_A_M     5'h04
`define OP_MOV_A_X     5'h05
`define OP_MOV_M_A     5'h06
`define OP_NOP         5'h07
`define OP_OR_A_M      5'h08
`define OP_OR_A_X      5'h09
`define OP_OR_M        5'h0A
`define OP_RET         5'h0B
`define OP_RET_A_X     5'h0C
`define OP_IRQ_RET     5'h0D
`define OP_ROT_L       5'h0E
`define OP_ROT_L_ACC   5'h0F
`define OP_ROT_LC      5'h10
`define OP_ROT_LC_ACC  5'h11
`define OP_ROT_R       5'h12
`define OP_ROT_R_ACC   5'h13
`define OP_ROT_RC      5'h14
`define OP_ROT_RC_ACC  5'h15

// Sizes and reset values
`define DMEM_DEPTH     160
`define STACK_DEPTH    6
`define RST_ACC        8'h00
`define RST_PC         12'h000
`define RST_WDT        8'h00

`endif

/* src/data_mem.v */
// Data memory of the execution unit: 160 bytes, synchronous write, direct read
`timescale 1ns/1ps
`include "exec_unit_defs.vh"

module data_mem (
   // Clock
   input wire clk,
   // Access port
   input wire [7:0] addr,
   input wire wr_en,
   input wire [7:0] wr_data,
   output wire [7:0] rd_data
);

   reg [7:0] mem [0:`DMEM_DEPTH-1];
   wire in_range;

   // Locations past the end read zero and ignore writes
   assign in_range = (addr < `DMEM_DEPTH);
   assign rd_data = in_range ? mem[addr] : 8'h00;

   // Write port; contents hold through halt since no reset touches them
   always @(posedge clk) begin
      if (wr_en && in_range) begin
         mem[addr] <= wr_data;
      end
   end

endmodule // data_mem

/* tb/apb_host.sv */
// APB master model driving the register port of the execution unit
`timescale 1ns/1ps

module apb_host (
   // Clock
   input wire logic pclk,
   // Request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   // Answer
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // Idle bus from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One transfer; request held until pready is seen high
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         q = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
endmodule // apb_host

/* tb/exec_unit_sva.sv */
// Port checks of the execution unit
`timescale 1ns/1ps
`include "exec_unit_defs.vh"

module exec_unit_sva (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Core status
   input wire logic halted,
   input wire logic global_irq_enable
);
   logic take_wr;
   logic [3:0] since_wr_reg;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Accepted write
   assign take_wr = psel && penable && pready && pwrite && !pslverr;

   // Cycles since the last accepted write, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         since_wr_reg <= 4'hF;
      else if (take_wr)
         since_wr_reg <= 4'h0;
      else if (since_wr_reg != 4'hF)
         since_wr_reg <= since_wr_reg + 4'h1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Transfer phases and accepted instructions
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable && !pready;
   endsequence
   sequence instr_s(logic [4:0] op);
      take_wr && paddr == `OFS_INSTR && pwdata[28:24] == op;
   endsequence

   chk_ready_late: assert property (setup_s ##1 access_s |=> pready)
      else $error("pready not in second access cycle");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_unmapped_rd: assert property (pready && !pwrite && paddr > `OFS_WDT |-> pslverr && prdata == 32'h0)
      else $error("unmapped read not refused");
   chk_halt_entry: assert property (instr_s(`OP_HALT) |-> ##[1:3] halted)
      else $error("power-down not entered");
   chk_halt_hold: assert property (halted && !(take_wr && paddr == `OFS_WAKE) |=> halted)
      else $error("power-down left without wake");
   chk_halt_cause: assert property ($rose(halted) |-> since_wr_reg <= 4'd3)
      else $error("power-down without instruction");
   chk_halt_frozen: assert property (halted ##1 halted |-> $stable(global_irq_enable))
      else $error("interrupt enable changed in power-down");
   chk_no_halt: assert property (take_wr && paddr == `OFS_INSTR && pwdata[28:24] != `OP_HALT |=> !halted [*4])
      else $error("halt from other instruction");
   chk_gie_set: assert property (instr_s(`OP_IRQ_RET) |-> ##[1:4] global_irq_enable)
      else $error("interrupt return left enable low");
   chk_gie_cause: assert property (!$stable(global_irq_enable) |-> since_wr_reg <= 4'd4)
      else $error("interrupt enable changed by itself");
endmodule // exec_unit_sva

bind exec_unit exec_unit_sva u_exec_unit_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .halted(halted), .global_irq_enable(global_irq_enable));

/* tb/mcu_exec_unit_halt_to_rotate_tb_top.sv */
// Self-checking bench of the execution unit
`timescale 1ns/1ps
`include "exec_unit_defs.vh"

module mcu_exec_unit_halt_to_rotate_tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, halted, global_irq_enable, e, c, z;
   logic [7:0] paddr, a, m, x, ad;
   logic [31:0] pwdata, prdata, q;
   logic [11:0] pc;
   logic [17:0] ex;
   integer num_errors, total_checks, seed, j, k, o;

   exec_unit u_exec_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .halted(halted), .global_irq_enable(global_irq_enable));
   apb_host u_apb_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // 125 MHz clock
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Compare and bus helpers
   task cmp(input string nm, input logic [31:0] ev, input logic [31:0] got);
      begin
         total_checks = total_checks + 1;
         if (got !== ev) begin
            num_errors = num_errors + 1;
            $display("ERROR %s expected %h seen %h", nm, ev, got);
         end
      end
   endtask
   task wr(input logic [7:0] av, input logic [31:0] d);
      u_apb_host.xfer(1'b1, av, d, q, e);
   endtask
   task rd(input logic [7:0] av);
      u_apb_host.xfer(1'b0, av, 32'h0, q, e);
   endtask
   // Issue one instruction, then poll busy under a bound
   task run(input logic [4:0] op, input logic [11:0] av, input logic [7:0] xv);
      begin
         wr(`OFS_INSTR, {3'h0, op, 4'h0, av, xv});
         k = 0;
         q = 32'h10;
         while (q[4] !== 1'b0 && k < 50) begin
            rd(`OFS_STATUS);
            k = k + 1;
         end
         cmp("busy", 32'h0, {31'h0, q[4]});
      end
   endtask
   task wrap_up;
      begin
         if (num_errors == 0 && total_checks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask

   // Expected {acc, mem, carry, zero} after one data instruction
   function logic [17:0] model(input logic [4:0] op, input logic [7:0] av, mv, xv,
      input logic cv, zv);
      logic [7:0] na, nm;
      logic nc, nz;
      begin
         na = av;
         nm = mv;
         nc = cv;
         nz = zv;
         case (op)
            `OP_INC: nm = mv + 8'h01;
            `OP_INCREMENT_TO_ACC_OP: na = mv + 8'h01;
            `OP_MOV_A_M: na = mv;
            `OP_MOV_A_X: na = xv;
            `OP_MOV_M_A: nm = av;
            `OP_OR_A_M: na = av | mv;
            `OP_OR_A_X: na = av | xv;
            `OP_OR_M: nm = av | mv;
            `OP_ROT_L: nm = {mv[6:0], mv[7]};
            `OP_ROT_L_ACC: na = {mv[6:0], mv[7]};
            `OP_ROT_LC: {nc, nm} = {mv, cv};
            `OP_ROT_LC_ACC: {nc, na} = {mv, cv};
            `OP_ROT_R: nm = {mv[0], mv[7:1]};
            `OP_ROT_R_ACC: na = {mv[0], mv[7:1]};
            `OP_ROT_RC: {nm, nc} = {cv, mv};
            `OP_ROT_RC_ACC: {na, nc} = {cv, mv};
            default: ;
         endcase
         if (op == `OP_INC || op == `OP_OR_M) nz = (nm == 8'h00);
         if (op == `OP_INCREMENT_TO_ACC_OP || op == `OP_OR_A_M || op == `OP_OR_A_X) nz = (na == 8'h00);
         model = {na, nm, nc, nz};
      end
   endfunction

   // Watchdog
   initial begin
      #400000;
      cmp("timeout", 32'h0, 32'h1);
      wrap_up;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      seed = 73;
      num_errors = 0;
      total_checks = 0;
      presetn = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(`OFS_ACC);
      cmp("acc_rst", 32'h0, q);
      rd(8'h40);
      cmp("unmapped_data", 32'h0, q);
      cmp("unmapped_err", 32'h1, {31'h0, e});
      // Data instructions, random operands, 0xFF wrap first
      for (j = 0; j < 6; j = j + 1)
         for (o = 1; o < 22; o = o + 1) begin
            if (o == 3 || (o > 10 && o < 14)) continue;
            a = $random(seed);
            m = (j == 0) ? 8'hFF : $random(seed);
            x = $random(seed);
            ad = {$random(seed)} % 160;
            {c, z} = $random(seed);
            pc = $random(seed);
            wr(`OFS_MEM_ADDR, {24'h0, ad});
            wr(`OFS_MEM_DATA, {24'h0, m});
            wr(`OFS_ACC, {24'h0, a});
            wr(`OFS_STATUS, {30'h0, z, c});
            wr(`OFS_PC, {20'h0, pc});
            run(o[4:0], {4'h0, ad}, x);
            ex = model(o[4:0], a, m, x, c, z);
            rd(`OFS_ACC);
            cmp("acc", {24'h0, ex[17:10]}, q);
            rd(`OFS_MEM_DATA);
            cmp("mem", {24'h0, ex[9:2]}, q);
            rd(`OFS_STATUS);
            cmp("status", {30'h0, ex[0], ex[1]}, q);
            rd(`OFS_PC);
            cmp("pc", {20'h0, pc + 12'h001}, q);
         end
      // Jump and the three returns
      for (o = 3; o < 14; o = o + 1) begin
         if (o > 3 && o < 11) continue;
         {c, z, a, x, pc} = $random(seed);
         wr(`OFS_STATUS, {30'h0, z, c});
         wr(`OFS_IRQ_CTRL, 32'h0);
         wr(`OFS_ACC, {24'h0, a});
         wr(`OFS_STACK, {20'h0, pc});
         run(o[4:0], ~pc, x);
         rd(`OFS_PC);
         cmp("pc_load", {20'h0, (o == 3) ? ~pc : pc}, q);
         rd(`OFS_ACC);
         cmp("acc_ret", {24'h0, (o == 12) ? x : a}, q);
         rd(`OFS_IRQ_CTRL);
         cmp("gie_reg", {31'h0, o == 13}, q);
         cmp("gie_pin", {31'h0, o == 13}, {31'h0, global_irq_enable});
         rd(`OFS_STATUS);
         cmp("flags_ret", {30'h0, z, c}, q);
      end
      // Undecoded opcode acts as no-operation and raises badop
      wr(`OFS_PC, {20'h0, pc});
      run(5'h1F, 12'h000, 8'h00);
      rd(`OFS_STATUS);
      cmp("badop", 32'h40, q & 32'h7C);
      rd(`OFS_PC);
      cmp("pc_badop", {20'h0, pc + 12'h001}, q);
      // Power-down, refused work, wake
      wr(`OFS_STATUS, 32'h0);
      wr(`OFS_ACC, {24'h0, a});
      wr(`OFS_PC, {20'h0, pc});
      wr(`OFS_INSTR, {3'h0, `OP_HALT, 24'h0});
      k = 0;
      while (halted !== 1'b1 && k < 20) begin
         @(posedge pclk);
         k = k + 1;
      end
      cmp("halted", 32'h1, {31'h0, halted});
      rd(`OFS_STATUS);
      cmp("pd_to", 32'h4, q & 32'hF);
      rd(`OFS_WDT);
      cmp("wdt", 32'h0, q);
      wr(`OFS_ACC, {24'h0, ~a});
      wr(`OFS_INSTR, {3'h0, `OP_NOP, 24'h0});
      cmp("refused", 32'h1, {31'h0, e});
      wr(`OFS_WAKE, 32'h0);
      rd(`OFS_ACC);
      cmp("acc_kept", {24'h0, a}, q);
      rd(`OFS_PC);
      cmp("pc_halt", {20'h0, pc + 12'h001}, q);
      wrap_up;
   end
endmodule // mcu_exec_unit_halt_to_rotate_tb_top
